// ---- rmp_consts.svh ----
// constants for the remote message parser: characters, keywords, reset values
`ifndef RMP_CONSTS_SVH
`define RMP_CONSTS_SVH

`define RMP_CH_LF 8'h0A
`define RMP_CH_CR 8'h0D
`define RMP_CH_SP 8'h20
`define RMP_CH_STAR 8'h2A
`define RMP_CH_COLON 8'h3A
`define RMP_CH_SEMI 8'h3B
`define RMP_CH_COMMA 8'h2C
`define RMP_CH_QUERY 8'h3F
`define RMP_CH_ZERO 8'h30
`define RMP_CASE_OFS 8'h20

// keyword spellings, long and short; RST has one spelling only
`define RMP_KW_HEAD_L "HEADER"
`define RMP_KW_HEAD_S "HEAD"
`define RMP_KW_TRAN_L "TRANSMIT"
`define RMP_KW_TRAN_S "TRAN"
`define RMP_KW_SEP_L "SEPARATOR"
`define RMP_KW_SEP_S "SEP"
`define RMP_KW_TERM_L "TERMINATOR"
`define RMP_KW_TERM_S "TERM"
`define RMP_KW_RST "RST"

// argument spellings
`define RMP_ARG_ON "ON"
`define RMP_ARG_OFF "OFF"
`define RMP_ARG_ONE "1"
`define RMP_ARG_NIL "0"

// response header names and their lengths
`define RMP_NM_HEAD "HEADER"
`define RMP_NM_HEAD_LEN 6
`define RMP_NM_SEP "TRANSMIT:SEPARATOR"
`define RMP_NM_SEP_LEN 18
`define RMP_NM_TERM "TRANSMIT:TERMINATOR"
`define RMP_NM_TERM_LEN 19

// buffer widths and limits
`define RMP_KW_BITS 80
`define RMP_ARG_BITS 32
`define RMP_ITEM_MAX 8'hFF
`define RMP_CODE_DIGITS 5'h02

// reset values of the settings
`define RMP_RST_HDR 1'b1
`define RMP_RST_COMMA 1'b0
`define RMP_RST_CRLF 1'b0

`endif

// ---- rmp_pkg.sv ----
// types of the remote message parser
package rmp_pkg;

	typedef enum {
		RMP_ST_HDR,
		RMP_ST_ARG,
		RMP_ST_QEND,
		RMP_ST_SEP,
		RMP_ST_BODY,
		RMP_ST_CR,
		RMP_ST_LF,
		RMP_ST_CODE
	} rmp_state_e;

	typedef enum logic [2:0] {
		RMP_KW_NONE,
		RMP_KW_HEAD,
		RMP_KW_TRAN,
		RMP_KW_SEP,
		RMP_KW_TERM,
		RMP_KW_RST
	} rmp_kw_e;

	typedef struct packed {
		logic [7:0] data;
		logic eoi;
	} rmp_byte_s;

endpackage : rmp_pkg

// ---- rmp_parser.sv ----
// remote message parser: program message parsing and response framing
// Contract
// - bytes in are program messages (commands or queries), bytes out are response messages.
// - a query answer starts as soon as the query unit has passed its syntax check.
// - with headers off the unit separator may be switched to comma; it starts as semicolon.
// - after each line up to its terminator a three digit ASCII confirmation code is sent.
// - a keyword is taken in its long or short spelling only, never in between.
// - keywords match with upper and lower case treated alike.
// - keywords in responses are sent long and in upper case.
// - a header setting, changed by its own command, includes or omits response headers.
// - a simple header element is made of letters and digits only.
// - a compound header is simple elements joined by colons.
// - a header starting with an asterisk is a standard common command.
// - a question mark right after the last element makes any header form a query; the code rejects a common command with a query (*RST?) as an error.
// - a line ends on linefeed, and on the GP-IB link also on EOI alone or with linefeed.
// - on GP-IB a response ends with a terminating sequence and EOI on its last byte.
// - the response terminator is linefeed (default) or carriage return plus linefeed.
`timescale 1ns/1ps
`default_nettype none
`include "rmp_consts.svh"

module rmp_parser (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic is_gpib,
	input wire rmp_pkg::rmp_byte_s rx_in,
	input wire logic rx_valid,
	output logic rx_ready,
	output rmp_pkg::rmp_byte_s tx_out,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic hdr_on,
	output logic sep_comma,
	output logic term_crlf
);
	import rmp_pkg::*;

	// keyword lookup, exact long or short spelling
	function automatic rmp_kw_e kw_lookup(input logic [`RMP_KW_BITS-1:0] k);
		kw_lookup = RMP_KW_NONE;
		if (k == `RMP_KW_BITS'(`RMP_KW_HEAD_L) || k == `RMP_KW_BITS'(`RMP_KW_HEAD_S)) begin
			kw_lookup = RMP_KW_HEAD;
		end else if (k == `RMP_KW_BITS'(`RMP_KW_TRAN_L) || k == `RMP_KW_BITS'(`RMP_KW_TRAN_S)) begin
			kw_lookup = RMP_KW_TRAN;
		end else if (k == `RMP_KW_BITS'(`RMP_KW_SEP_L) || k == `RMP_KW_BITS'(`RMP_KW_SEP_S)) begin
			kw_lookup = RMP_KW_SEP;
		end else if (k == `RMP_KW_BITS'(`RMP_KW_TERM_L) || k == `RMP_KW_BITS'(`RMP_KW_TERM_S)) begin
			kw_lookup = RMP_KW_TERM;
		end else if (k == `RMP_KW_BITS'(`RMP_KW_RST)) begin
			kw_lookup = RMP_KW_RST;
		end
	endfunction : kw_lookup

	// response byte: {last, byte} for the answer of one query
	function automatic logic [8:0] resp_byte(input rmp_kw_e q, input logic [4:0] idx,
			input logic hdr, input logic val);
		logic [151:0] nm;
		int len;
		int pos;
		nm = 152'(`RMP_NM_HEAD);
		len = `RMP_NM_HEAD_LEN;
		pos = 0;
		if (q == RMP_KW_SEP) begin
			nm = 152'(`RMP_NM_SEP);
			len = `RMP_NM_SEP_LEN;
		end else if (q == RMP_KW_TERM) begin
			nm = 152'(`RMP_NM_TERM);
			len = `RMP_NM_TERM_LEN;
		end
		if (!hdr) begin
			len = 0; // header omitted
		end
		if (int'(idx) < len) begin
			pos = (len - 1 - int'(idx)) * 8;
			resp_byte = {1'b0, nm[pos +: 8]}; // long upper case name
		end else if (int'(idx) == len && hdr) begin
			resp_byte = {1'b0, `RMP_CH_SP};
		end else begin
			resp_byte = {1'b1, `RMP_CH_ZERO + {7'h00, val}};
		end
	endfunction : resp_byte

	// reset release through two flops
	logic [1:0] rsync_ff;
	logic rst_s_n;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsync_ff <= 2'b00;
		end else begin
			rsync_ff <= {rsync_ff[0], 1'b1};
		end
	end
	assign rst_s_n = rsync_ff[1];

	rmp_state_e st_ff, nxt_st;
	logic [`RMP_KW_BITS-1:0] kw_ff, nxt_kw;
	logic [`RMP_ARG_BITS-1:0] arg_ff, nxt_arg;
	rmp_kw_e e0_ff, nxt_e0, e1_ff, nxt_e1, rq_ff, nxt_rq;
	logic [1:0] ne_ff, nxt_ne;
	logic [7:0] unit_ff, nxt_unit, err_ff, nxt_err;
	logic [4:0] idx_ff, nxt_idx;
	logic star_ff, nxt_star, qry_ff, nxt_qry, bad_ff, nxt_bad, ovf_ff, nxt_ovf;
	logic hdr_ff, nxt_hdr, comma_ff, nxt_comma, crlf_ff, nxt_crlf;
	logic any_ff, nxt_any, line_ff, nxt_line, code_ff, nxt_code, pend_ff, nxt_pend;
	logic txv_ff, nxt_txv, rxr_ff, nxt_rxr;
	rmp_byte_s txb_ff, nxt_txb;

	// parser and response sequencer next state
	always_comb begin
		logic [7:0] ch;
		logic [7:0] up;
		logic [8:0] rb;
		logic take;
		logic alnum;
		logic res;
		logic do_end;
		logic end_ln;
		logic tx_free;
		logic empty;
		logic arg_one;
		logic arg_ok;
		logic [7:0] dig;
		rmp_kw_e el;
		rmp_state_e term_st;
		ch = rx_in.data;
		up = (ch >= 8'h61 && ch <= 8'h7A) ? ch - `RMP_CASE_OFS : ch; // fold case
		alnum = (up >= 8'h30 && up <= 8'h39) || (up >= 8'h41 && up <= 8'h5A);
		take = rx_valid && rxr_ff;
		tx_free = !txv_ff || tx_ready;
		res = 1'b0;
		do_end = 1'b0;
		end_ln = 1'b0;
		empty = 1'b0;
		el = RMP_KW_NONE;
		arg_one = 1'b0;
		arg_ok = 1'b0;
		rb = 9'h000;
		dig = 8'h00;
		term_st = crlf_ff ? RMP_ST_CR : RMP_ST_LF;
		nxt_st = st_ff;
		nxt_kw = kw_ff;
		nxt_arg = arg_ff;
		nxt_e0 = e0_ff;
		nxt_e1 = e1_ff;
		nxt_rq = rq_ff;
		nxt_ne = ne_ff;
		nxt_unit = unit_ff;
		nxt_err = err_ff;
		nxt_idx = idx_ff;
		nxt_star = star_ff;
		nxt_qry = qry_ff;
		nxt_bad = bad_ff;
		nxt_ovf = ovf_ff;
		nxt_hdr = hdr_ff;
		nxt_comma = comma_ff;
		nxt_crlf = crlf_ff;
		nxt_any = any_ff;
		nxt_line = line_ff;
		nxt_code = code_ff;
		nxt_pend = pend_ff;
		nxt_txv = txv_ff && !tx_ready;
		nxt_txb = txb_ff;
		// incoming characters of a program message
		if (st_ff == RMP_ST_HDR || st_ff == RMP_ST_ARG || st_ff == RMP_ST_QEND) begin
			if (pend_ff) begin
				nxt_pend = 1'b0; // deferred end after a data byte with EOI
				res = (st_ff == RMP_ST_HDR); // close the open element too
				do_end = 1'b1;
				end_ln = 1'b1;
			end else if (take) begin
				if (ch == `RMP_CH_LF) begin
					res = (st_ff == RMP_ST_HDR); // linefeed ends the line
					do_end = 1'b1;
					end_ln = 1'b1;
				end else begin
					nxt_pend = rx_in.eoi && is_gpib; // on GP-IB only, EOI alone ends the line
					case (st_ff)
						RMP_ST_HDR: begin
							if (alnum) begin
								nxt_ovf = ovf_ff || (kw_ff[`RMP_KW_BITS-1 -: 8] != 8'h00);
								nxt_kw = {kw_ff[`RMP_KW_BITS-9:0], up};
							end else if (ch == `RMP_CH_STAR) begin
								nxt_star = 1'b1; // standard common command
								nxt_bad = bad_ff || kw_ff != '0 || ne_ff != 2'd0 || star_ff;
							end else if (ch == `RMP_CH_COLON) begin
								// leading colon is allowed, others split elements
								res = !(kw_ff == '0 && ne_ff == 2'd0 && !star_ff);
							end else if (ch == `RMP_CH_QUERY) begin
								res = 1'b1;
								nxt_qry = 1'b1; // query on the last element
								nxt_st = RMP_ST_QEND;
							end else if (ch == `RMP_CH_SP) begin
								res = 1'b1;
								nxt_st = RMP_ST_ARG;
							end else if (ch == `RMP_CH_SEMI) begin
								res = 1'b1;
								do_end = 1'b1;
							end else begin
								nxt_bad = 1'b1;
							end
						end
						RMP_ST_ARG: begin
							if (alnum) begin
								nxt_ovf = ovf_ff || (arg_ff[`RMP_ARG_BITS-1 -: 8] != 8'h00);
								nxt_arg = {arg_ff[`RMP_ARG_BITS-9:0], up};
							end else if (ch == `RMP_CH_SEMI) begin
								do_end = 1'b1;
							end else if (ch != `RMP_CH_SP) begin
								nxt_bad = 1'b1;
							end
						end
						default: begin
							if (ch == `RMP_CH_SEMI) begin
								do_end = 1'b1;
							end else if (ch != `RMP_CH_SP) begin
								nxt_bad = 1'b1;
							end
						end
					endcase
				end
			end
		end
		// close one header element
		if (res) begin
			el = kw_lookup(kw_ff);
			if (kw_ff == '0 && !do_end) begin
				nxt_bad = 1'b1;
			end else if (kw_ff != '0) begin
				if (el == RMP_KW_NONE || ovf_ff || ne_ff == 2'd2) begin
					nxt_bad = 1'b1; // unknown, overlong or third element
				end else if (ne_ff == 2'd0) begin
					nxt_e0 = el;
				end else begin
					nxt_e1 = el;
				end
				nxt_ne = ne_ff + 2'd1;
			end
			nxt_kw = '0;
			nxt_ovf = 1'b0;
		end
		// execute one message unit
		if (do_end) begin
			empty = nxt_ne == 2'd0 && !nxt_star && !nxt_qry && nxt_arg == '0 && !nxt_bad;
			arg_one = nxt_arg == `RMP_ARG_BITS'(`RMP_ARG_ON)
				|| nxt_arg == `RMP_ARG_BITS'(`RMP_ARG_ONE);
			arg_ok = arg_one || nxt_arg == `RMP_ARG_BITS'(`RMP_ARG_OFF)
				|| nxt_arg == `RMP_ARG_BITS'(`RMP_ARG_NIL);
			nxt_rq = RMP_KW_NONE;
			if (!empty) begin
				if (nxt_star) begin
					if (nxt_ne == 2'd1 && nxt_e0 == RMP_KW_RST && !nxt_qry && nxt_arg == '0
							&& !nxt_bad) begin
						nxt_hdr = `RMP_RST_HDR;
						nxt_comma = `RMP_RST_COMMA;
						nxt_crlf = `RMP_RST_CRLF;
					end else begin
						nxt_bad = 1'b1;
					end
				end else if (nxt_ne == 2'd1 && nxt_e0 == RMP_KW_HEAD) begin
					nxt_rq = RMP_KW_HEAD;
				end else if (nxt_ne == 2'd2 && nxt_e0 == RMP_KW_TRAN
						&& (nxt_e1 == RMP_KW_SEP || nxt_e1 == RMP_KW_TERM)) begin
					nxt_rq = nxt_e1;
				end else begin
					nxt_bad = 1'b1; // no header or no such command
				end
				if (nxt_rq != RMP_KW_NONE && !nxt_bad) begin
					if (nxt_qry) begin
						nxt_bad = nxt_arg != '0;
					end else if (!arg_ok) begin
						nxt_bad = 1'b1;
					end else if (nxt_rq == RMP_KW_HEAD) begin
						nxt_hdr = arg_one; // header control
					end else if (nxt_rq == RMP_KW_SEP) begin
						nxt_comma = arg_one;
					end else begin
						nxt_crlf = arg_one;
					end
				end
				if (nxt_bad && err_ff == 8'h00) begin
					nxt_err = unit_ff; // first failing item
				end
				if (unit_ff != `RMP_ITEM_MAX) begin
					nxt_unit = unit_ff + 8'h01;
				end
			end
			nxt_st = RMP_ST_HDR;
			if (nxt_qry && !nxt_bad && nxt_rq != RMP_KW_NONE) begin
				nxt_st = any_ff ? RMP_ST_SEP : RMP_ST_BODY; // answer at once
				nxt_any = 1'b1;
				nxt_idx = 5'h00;
			end else if (end_ln) begin
				nxt_st = any_ff ? term_st : RMP_ST_CODE;
				nxt_idx = 5'h00;
			end
			nxt_line = end_ln;
			nxt_kw = '0;
			nxt_arg = '0;
			nxt_ne = 2'd0;
			nxt_star = 1'b0;
			nxt_qry = 1'b0;
			nxt_bad = 1'b0;
			nxt_ovf = 1'b0;
		end
		// response byte sequencer
		if (tx_free) begin
			case (st_ff)
				RMP_ST_SEP: begin
					nxt_txv = 1'b1;
					nxt_txb = '{(comma_ff && !hdr_ff) ? `RMP_CH_COMMA : `RMP_CH_SEMI, 1'b0};
					nxt_st = RMP_ST_BODY;
				end
				RMP_ST_BODY: begin
					rb = resp_byte(rq_ff, idx_ff, hdr_ff,
						rq_ff == RMP_KW_HEAD ? hdr_ff : (rq_ff == RMP_KW_SEP ? comma_ff : crlf_ff));
					nxt_txv = 1'b1;
					nxt_txb = '{rb[7:0], 1'b0};
					nxt_idx = idx_ff + 5'h01;
					if (rb[8]) begin
						nxt_idx = 5'h00;
						nxt_st = line_ff ? term_st : RMP_ST_HDR;
					end
				end
				RMP_ST_CR: begin
					nxt_txv = 1'b1;
					nxt_txb = '{`RMP_CH_CR, 1'b0};
					nxt_st = RMP_ST_LF;
				end
				RMP_ST_LF: begin
					nxt_txv = 1'b1;
					nxt_txb = '{`RMP_CH_LF, is_gpib}; // EOI on the final byte
					if (code_ff) begin
						nxt_st = RMP_ST_HDR;
						nxt_code = 1'b0;
						nxt_line = 1'b0;
						nxt_any = 1'b0;
						nxt_err = 8'h00;
						nxt_unit = 8'h01;
					end else begin
						nxt_st = RMP_ST_CODE;
						nxt_idx = 5'h00;
					end
				end
				RMP_ST_CODE: begin
					case (idx_ff)
						5'h00: dig = err_ff / 8'd100;
						5'h01: dig = (err_ff / 8'd10) % 8'd10;
						default: dig = err_ff % 8'd10;
					endcase
					nxt_txv = 1'b1;
					nxt_txb = '{`RMP_CH_ZERO + dig, 1'b0}; // confirmation digit
					nxt_idx = idx_ff + 5'h01;
					if (idx_ff == `RMP_CODE_DIGITS) begin
						nxt_code = 1'b1;
						nxt_st = term_st;
					end
				end
				default: begin
				end
			endcase
		end
		nxt_rxr = !nxt_pend && (nxt_st == RMP_ST_HDR || nxt_st == RMP_ST_ARG
			|| nxt_st == RMP_ST_QEND) && !(do_end && nxt_st != st_ff);
	end

	// state registers
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			st_ff <= RMP_ST_HDR;
			kw_ff <= '0;
			arg_ff <= '0;
			e0_ff <= RMP_KW_NONE;
			e1_ff <= RMP_KW_NONE;
			rq_ff <= RMP_KW_NONE;
			ne_ff <= 2'd0;
			unit_ff <= 8'h01;
			err_ff <= 8'h00;
			idx_ff <= 5'h00;
			star_ff <= 1'b0;
			qry_ff <= 1'b0;
			bad_ff <= 1'b0;
			ovf_ff <= 1'b0;
			hdr_ff <= `RMP_RST_HDR;
			comma_ff <= `RMP_RST_COMMA;
			crlf_ff <= `RMP_RST_CRLF;
			any_ff <= 1'b0;
			line_ff <= 1'b0;
			code_ff <= 1'b0;
			pend_ff <= 1'b0;
			txv_ff <= 1'b0;
			txb_ff <= '0;
			rxr_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			kw_ff <= nxt_kw;
			arg_ff <= nxt_arg;
			e0_ff <= nxt_e0;
			e1_ff <= nxt_e1;
			rq_ff <= nxt_rq;
			ne_ff <= nxt_ne;
			unit_ff <= nxt_unit;
			err_ff <= nxt_err;
			idx_ff <= nxt_idx;
			star_ff <= nxt_star;
			qry_ff <= nxt_qry;
			bad_ff <= nxt_bad;
			ovf_ff <= nxt_ovf;
			hdr_ff <= nxt_hdr;
			comma_ff <= nxt_comma;
			crlf_ff <= nxt_crlf;
			any_ff <= nxt_any;
			line_ff <= nxt_line;
			code_ff <= nxt_code;
			pend_ff <= nxt_pend;
			txv_ff <= nxt_txv;
			txb_ff <= nxt_txb;
			rxr_ff <= nxt_rxr;
		end
	end

	// outputs straight from flops
	assign rx_ready = rxr_ff;
	assign tx_valid = txv_ff;
	assign tx_out = txb_ff;
	assign hdr_on = hdr_ff;
	assign sep_comma = comma_ff;
	assign term_crlf = crlf_ff;

endmodule : rmp_parser
`default_nettype wire

// ---- rmp_parser_props.sv ----
// concurrent checks on the remote message parser ports
`timescale 1ns/1ps
`default_nettype none
`include "rmp_consts.svh"

module rmp_parser_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic is_gpib,
	input wire rmp_pkg::rmp_byte_s rx_in,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire rmp_pkg::rmp_byte_s tx_out,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic hdr_on,
	input wire logic sep_comma,
	input wire logic term_crlf
);
	import rmp_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic rx_take;
	logic tx_take;
	logic line_end;
	// handshakes and the end of a received line
	assign rx_take = rx_valid && rx_ready;
	assign tx_take = tx_valid && tx_ready;
	assign line_end = rx_take && (rx_in.data == `RMP_CH_LF || (is_gpib && rx_in.eoi));

	property p_rst_vals;
		$rose(rst_n) |-> hdr_on && !sep_comma && !term_crlf;
	endproperty
	a_rst_vals: assert property (p_rst_vals)
		else $error("settings not at reset values");
	property p_tx_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_out);
	endproperty
	a_tx_hold: assert property (p_tx_hold)
		else $error("reply byte dropped or changed while stalled");
	property p_eoi_last;
		tx_valid && tx_out.eoi |-> is_gpib && tx_out.data == `RMP_CH_LF;
	endproperty
	a_eoi_last: assert property (p_eoi_last)
		else $error("eoi on a byte other than a gpib linefeed");
	property p_lf_eoi;
		tx_valid && is_gpib && tx_out.data == `RMP_CH_LF |-> tx_out.eoi;
	endproperty
	a_lf_eoi: assert property (p_lf_eoi)
		else $error("gpib linefeed sent without eoi");
	property p_cr_lf;
		tx_take && tx_out.data == `RMP_CH_CR |-> ##[1:2] tx_valid && tx_out.data == `RMP_CH_LF;
	endproperty
	a_cr_lf: assert property (p_cr_lf)
		else $error("carriage return not followed by linefeed");
	property p_upper;
		tx_valid |-> !(tx_out.data inside {[8'h61:8'h7A]});
	endproperty
	a_upper: assert property (p_upper)
		else $error("lower case letter in a reply");
	property p_comma;
		tx_valid && tx_out.data == `RMP_CH_COMMA |-> !hdr_on && sep_comma;
	endproperty
	a_comma: assert property (p_comma)
		else $error("comma sent while not selected");
	property p_line_stop;
		line_end |=> !rx_ready;
	endproperty
	a_line_stop: assert property (p_line_stop)
		else $error("still taking bytes after a line end");
	property p_confirm;
		line_end |-> ##[1:4] tx_valid;
	endproperty
	a_confirm: assert property (p_confirm)
		else $error("no reply after a line end");

	// main scenarios reached
	c_comma: cover property (tx_take && tx_out.data == `RMP_CH_COMMA);
	c_crlf: cover property (tx_take && tx_out.data == `RMP_CH_CR);
	c_eoi: cover property (tx_take && tx_out.eoi);
	c_stall: cover property (tx_valid && !tx_ready);
endmodule : rmp_parser_props
`default_nettype wire

// ---- rmp_ctrl_model.sv ----
// controller model: sends program lines, collects replies
`timescale 1ns/1ps
`default_nettype none

module rmp_ctrl_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic rx_ready,
	input wire rmp_pkg::rmp_byte_s tx_out,
	input wire logic tx_valid,
	output rmp_pkg::rmp_byte_s rx_in,
	output logic rx_valid,
	output logic tx_ready
);
	import rmp_pkg::*;
	logic slow;
	logic odd;
	rmp_byte_s got[$];
	initial begin
		rx_in = '0;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
		slow = 1'b0;
		odd = 1'b0;
	end
	// reply sink, stalling every other cycle when slow
	always @(posedge clk) begin
		if (tx_valid && tx_ready) begin
			got.push_back(tx_out);
		end
		odd <= ~odd;
		tx_ready <= rst_n && !(slow && odd);
	end
	// one line, held per byte until taken; eoi may mark the last byte
	task automatic send(input string s, input logic eoi_end);
		for (int i = 0; i < s.len(); i++) begin
			rx_in <= '{data: s[i], eoi: eoi_end && i == s.len() - 1};
			rx_valid <= 1'b1;
			do @(negedge clk); while (!rx_ready);
			@(posedge clk);
		end
		rx_valid <= 1'b0;
		rx_in <= rmp_byte_s'(~rx_in);  // released line shows no stale byte
	endtask : send
endmodule : rmp_ctrl_model
`default_nettype wire

// ---- rmp_parser_bench.sv ----
// self-checking bench for the remote message parser
`timescale 1ns/1ps
`default_nettype none

module rmp_parser_bench;
	import rmp_pkg::*;
	logic clk, rst_n, is_gpib, rx_valid, rx_ready, tx_valid, tx_ready;
	logic hdr_on, sep_comma, term_crlf;
	rmp_byte_s rx_in, tx_out;
	int fail_count, n_compared;

	rmp_parser u_rmp_parser (.clk(clk), .rst_n(rst_n), .is_gpib(is_gpib), .rx_in(rx_in),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_out(tx_out), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .hdr_on(hdr_on), .sep_comma(sep_comma), .term_crlf(term_crlf));
	rmp_ctrl_model u_rmp_ctrl_model (.clk(clk), .rst_n(rst_n), .rx_ready(rx_ready),
		.tx_out(tx_out), .tx_valid(tx_valid), .rx_in(rx_in), .rx_valid(rx_valid),
		.tx_ready(tx_ready));

	// compare one value and count it
	task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t ns: %s got %h want %h", $time, what, seen, exp);
		end
	endtask : check
	// send one line and compare the whole reply, eoi expected on gpib linefeeds
	task automatic xact(input string cmd, input string exp, input logic eoi_end);
		int k;
		u_rmp_ctrl_model.send(cmd, eoi_end);
		for (k = 0; k < 600 && u_rmp_ctrl_model.got.size() < exp.len(); k++) @(posedge clk);
		repeat (30) @(posedge clk);
		check(9'(u_rmp_ctrl_model.got.size()), 9'(exp.len()), "reply length");
		for (k = 0; k < exp.len() && k < u_rmp_ctrl_model.got.size(); k++) begin
			check(u_rmp_ctrl_model.got[k], {exp[k], is_gpib && exp[k] == 8'h0A}, "reply");
		end
		u_rmp_ctrl_model.got.delete();
	endtask : xact
	// let a reply pass unchecked
	task automatic settle;
		repeat (60) @(posedge clk);
		u_rmp_ctrl_model.got.delete();
	endtask : settle

	// settings after reset and a first query
	task automatic t_reset;
		check(9'(hdr_on), 9'h001, "header setting");
		check(9'(sep_comma), 9'h000, "separator setting");
		check(9'(term_crlf), 9'h000, "terminator setting");
		xact("HEAD?\n", "HEADER 1\n000\n", 1'b0);
		$display("reset test done");
	endtask : t_reset
	// spellings, case, bad characters and error item numbers
	task automatic t_spell;
		xact("header?\n", "HEADER 1\n000\n", 1'b0);
		xact("hEaD?\n", "HEADER 1\n000\n", 1'b0);
		xact("HEADE?\n", "001\n", 1'b0);
		xact("HE-AD?\n", "001\n", 1'b0);
		xact("?\n", "001\n", 1'b0);
		xact("*RST?\n", "001\n", 1'b0);
		xact("HEAD?;NOPE;HEAD?\n", "HEADER 1;HEADER 1\n002\n", 1'b0);
		$display("spelling test done");
	endtask : t_spell
	// compound headers with the reply stream stalled
	task automatic t_compound;
		u_rmp_ctrl_model.slow <= 1'b1;
		xact(":TRANSMIT:SEPARATOR?;tran:sep?\n",
			"TRANSMIT:SEPARATOR 0;TRANSMIT:SEPARATOR 0\n000\n", 1'b0);
		xact("TRANS:SEP?\n", "001\n", 1'b0);
		u_rmp_ctrl_model.slow <= 1'b0;
		$display("compound test done");
	endtask : t_compound
	// comma only with headers off
	task automatic t_sep;
		xact("HEAD 0;TRAN:SEP 1;TRAN:SEP?;HEAD?\n", "1,0\n000\n", 1'b0);
		check(9'({hdr_on, sep_comma}), 9'h001, "settings");
		xact("HEAD 1;HEAD?;HEAD?\n", "HEADER 1;HEADER 1\n000\n", 1'b0);
		xact("TRAN:SEP 0\n", "000\n", 1'b0);
		xact("tran:terminator?\n", "TRANSMIT:TERMINATOR 0\n000\n", 1'b0);
		xact("HEAD OFF;HEAD?;HEAD ON\n", "0\n000\n", 1'b0);
		check(9'(hdr_on), 9'h001, "header setting");
		$display("separator test done");
	endtask : t_sep
	// gpib link: crlf terminator, eoi endings, common reset command
	task automatic t_gpib;
		is_gpib <= 1'b1;
		@(posedge clk);
		u_rmp_ctrl_model.send("TRAN:TERM 1\n", 1'b0);
		settle();
		check(9'(term_crlf), 9'h001, "terminator setting");
		xact("HEAD?", "HEADER 1\015\n000\015\n", 1'b1);
		xact("HEAD?\n", "HEADER 1\015\n000\015\n", 1'b1);
		u_rmp_ctrl_model.send("HEAD 0;*RST", 1'b1); // eoi alone ends the line
		settle();
		check(9'({hdr_on, term_crlf}), 9'h002, "settings");
		xact("*rst;HEAD?\n", "HEADER 1\n000\n", 1'b1);
		is_gpib <= 1'b0;
		$display("gpib test done");
	endtask : t_gpib
	// serial link: eoi alone does not end a line
	task automatic t_serial;
		u_rmp_ctrl_model.send("HEAD?", 1'b1);
		repeat (30) @(posedge clk);
		check(9'(u_rmp_ctrl_model.got.size()), 9'h000, "early reply");
		xact("\n", "HEADER 1\n000\n", 1'b0);
		$display("serial test done");
	endtask : t_serial

	// counts and verdict
	task automatic conclude;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	// clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// reset, then the scenarios
	initial begin
		rst_n = 1'b0;
		is_gpib = 1'b0;
		fail_count = 0;
		n_compared = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset();
		t_spell();
		t_compound();
		t_sep();
		t_gpib();
		t_serial();
		conclude();
	end
	// watchdog against a hang
	initial begin
		#(25 * 30000);
		fail_count++;
		$display("wrong value at %0t ns: run timed out", $time);
		conclude();
	end
endmodule : rmp_parser_bench

bind rmp_parser rmp_parser_props u_rmp_parser_props (.clk(clk), .rst_n(rst_n),
	.is_gpib(is_gpib), .rx_in(rx_in), .rx_valid(rx_valid), .rx_ready(rx_ready),
	.tx_out(tx_out), .tx_valid(tx_valid), .tx_ready(tx_ready), .hdr_on(hdr_on),
	.sep_comma(sep_comma), .term_crlf(term_crlf));
`default_nettype wire
